// ---- rtl/aio_params.svh ----
// constants for the analog current i/o status logic
// Function
// - status claims 24 bits, byte aligned base
// - byte one: self test, supply, data invalid
// - byte two: open loop for inputs 1-4
// - byte three always reads zero
// - open loop only in 4-20 mA, below 3.75mA
// - 15-bit mode counts span 0 to 32767
// - 16-bit mode counts span 0 to 65535 unsigned
// - fault drives 0 mA or 4 mA per range
// - one output refreshed per 2.5 ms slot, enabled channels alternate
`ifndef AIO_PARAMS_SVH
`define AIO_PARAMS_SVH

// ==========================================================
// bus geometry
`define ADDR_W 8
`define DATA_W 16
`define STAT_W 8

// ==========================================================
// register map, status area starts on a byte boundary
`define ADDR_MOD_STAT 8'h00
`define ADDR_OPEN_STAT 8'h01
`define ADDR_SPARE_STAT 8'h02
`define ADDR_CFG 8'h03
`define ADDR_IN0 8'h04
`define ADDR_IN3 8'h07
`define ADDR_OUT0 8'h08
`define ADDR_OUT1 8'h09

// ==========================================================
// reset values
`define CFG_RESET 10'h3FC
`define COUNT_RESET 16'h0000

// ==========================================================
// converter codes, hardware full scale 0..20 mA on 16 bits
`define CODE_ZERO 16'h0000
`define CODE_4MA 16'h3333
`define CODE_OPEN 16'h3000
`define CODE_MAX 16'hFFFF
`define SCALE_4_5 16'hCCCC

// ==========================================================
// timing
`define CLK_MHZ 50
`define REFRESH_US 2500
`define FIFO_DEPTH 4

`endif

// ---- rtl/aio_pkg.sv ----
// types shared by the analog current i/o status logic
package aio_pkg;
    // one converted input sample
    typedef struct packed {
        logic [1:0] chan;
        logic [15:0] raw;
    } sample_t;

    // software configuration word
    typedef struct packed {
        logic [3:0] in_4_20;
        logic [1:0] out_4_20;
        logic [1:0] out_en;
        logic mode16;
        logic fault;
    } cfg_t;

    // one converter load
    typedef struct packed {
        logic chan;
        logic [15:0] code;
    } dac_word_t;
endpackage

// ---- rtl/analog_current_io_status_logic.sv ----
// digital side of the combination analog current module
`timescale 1ns/100ps
`include "aio_params.svh"
module analog_current_io_status_logic #(
    parameter int REFRESH_CYCLES = `REFRESH_US * `CLK_MHZ
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire logic [`ADDR_W-1:0] reg_addr,
    input wire logic [`DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`DATA_W-1:0] reg_rdata,
    // input converter samples
    input wire logic adc_valid,
    output logic adc_ready,
    input wire aio_pkg::sample_t adc_sample,
    // output converter
    output logic dac_load,
    output aio_pkg::dac_word_t dac_word,
    // module pins
    input wire logic supply_ok_pin,
    input wire logic selftest_fail_pin
);
    import aio_pkg::*;

    cfg_t cfg;
    logic [15:0] in_count [4];
    logic [15:0] scaled [4];
    logic [15:0] out_count [2];
    logic [3:0] open_raw;
    logic [3:0] open_loop;
    logic [3:0] seen;
    logic supply_meta;
    logic supply_sync;
    logic fail_meta;
    logic fail_sync;
    logic supply_absent_flag;
    logic in_invalid;
    logic out_invalid;
    logic fault_active;
    logic [7:0] module_error_flags;
    logic [7:0] open_loop_flags;
    logic [7:0] spare_status_byte;
    logic fifo_valid;
    logic fifo_ready;
    sample_t fifo_out;
    logic pop;
    logic [31:0] tick_cnt;
    logic tick;
    logic cur_chan;
    logic next_chan;
    logic [31:0] gap_cnt;
    logic [1:0] in_idx;

    // ==========================================================
    // pin synchronisers
    // ==========================================================
    // first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            supply_meta <= 1'b0;
            supply_sync <= 1'b0;
            fail_meta <= 1'b0;
            fail_sync <= 1'b0;
        end else begin
            supply_meta <= supply_ok_pin;
            supply_sync <= supply_meta;
            fail_meta <= selftest_fail_pin;
            fail_sync <= fail_meta;
        end
    end

    // ==========================================================
    // sample path
    // ==========================================================
    // fifo absorbs bursts; drain pauses on host reads so a count
    // never changes under the read that is sampling it
    sample_fifo #(
        .WIDTH($bits(sample_t)),
        .DEPTH(`FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(adc_valid),
        .in_ready(adc_ready),
        .in_data(adc_sample),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_out)
    );
    assign fifo_ready = !reg_rd;
    assign pop = fifo_valid && fifo_ready;

    // one scaler per input channel
    for (genvar i = 0; i < 4; i++) begin : g_scale
        in_scale u_scale (
            .raw(fifo_out.raw),
            .range_4_20(cfg.in_4_20[i]),
            .mode16(cfg.mode16),
            .count(scaled[i])
        );
    end

    // counts update on each popped sample of their channel
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) in_count[i] <= `COUNT_RESET;
        end else if (pop) begin
            in_count[fifo_out.chan] <= scaled[fifo_out.chan];
        end
    end

    // open loop judged on the raw current of each sample
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            open_raw <= 4'h0;
        end else begin
            // a sample landing with a config write still counts, set wins
            if (reg_wr && reg_addr == `ADDR_CFG) open_raw <= 4'h0;
            if (pop) open_raw[fifo_out.chan] <= cfg.in_4_20[fifo_out.chan]
                && (fifo_out.raw < `CODE_OPEN);
        end
    end
    // masked too, so a range change never shows a stale flag
    assign open_loop = open_raw & cfg.in_4_20;

    // a channel is fresh once sampled since the last config write
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            seen <= 4'h0;
        end else if (reg_wr && reg_addr == `ADDR_CFG) begin
            seen <= 4'h0;
        end else if (pop) begin
            seen[fifo_out.chan] <= 1'b1;
        end
    end

    // ==========================================================
    // status area
    // ==========================================================
    assign supply_absent_flag = !supply_sync;
    assign fault_active = cfg.fault || fail_sync;
    assign in_invalid = !(&seen) || supply_absent_flag || fail_sync;
    assign out_invalid = fault_active || supply_absent_flag;
    assign module_error_flags = {4'h0, out_invalid, in_invalid,
        supply_absent_flag, fail_sync};
    assign open_loop_flags = {4'h0, open_loop};
    assign spare_status_byte = 8'h00;

    // ==========================================================
    // register writes
    // ==========================================================
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cfg <= `CFG_RESET;
        end else if (reg_wr && reg_addr == `ADDR_CFG) begin
            cfg <= reg_wdata[$bits(cfg_t)-1:0];
        end
    end

    // output counts; the host is trusted to check the invalid flag
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            out_count[0] <= `COUNT_RESET;
            out_count[1] <= `COUNT_RESET;
        end else if (reg_wr && reg_addr == `ADDR_OUT0) begin
            out_count[0] <= reg_wdata;
        end else if (reg_wr && reg_addr == `ADDR_OUT1) begin
            out_count[1] <= reg_wdata;
        end
    end

    // ==========================================================
    // register reads, data only in the cycle after the strobe
    // ==========================================================
    assign in_idx = 2'(reg_addr - `ADDR_IN0);
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !reg_rd) begin
            reg_rdata <= '0;
        end else if (reg_addr == `ADDR_MOD_STAT) begin
            reg_rdata <= `DATA_W'(module_error_flags);
        end else if (reg_addr == `ADDR_OPEN_STAT) begin
            reg_rdata <= `DATA_W'(open_loop_flags);
        end else if (reg_addr == `ADDR_SPARE_STAT) begin
            reg_rdata <= `DATA_W'(spare_status_byte);
        end else if (reg_addr == `ADDR_CFG) begin
            reg_rdata <= `DATA_W'(cfg);
        end else if (reg_addr >= `ADDR_IN0 && reg_addr <= `ADDR_IN3) begin
            reg_rdata <= in_count[in_idx];
        end else if (reg_addr == `ADDR_OUT0) begin
            reg_rdata <= out_count[0];
        end else if (reg_addr == `ADDR_OUT1) begin
            reg_rdata <= out_count[1];
        end else begin
            reg_rdata <= '0;
        end
    end

    // ==========================================================
    // output refresh
    // ==========================================================
    // count to converter code, fault forces the range's rest level
    function automatic logic [15:0] out_code(input logic [15:0] cnt,
        input logic r420, input logic m16, input logic flt);
        logic [15:0] full;
        logic [31:0] prod;
        full = m16 ? cnt : {cnt[14:0], 1'b0};
        prod = full * `SCALE_4_5;
        if (flt) begin
            return r420 ? `CODE_4MA : `CODE_ZERO;
        end else if (r420) begin
            return `CODE_4MA + prod[31:16];
        end else begin
            return full;
        end
    endfunction

    // one refresh slot per interval, shared by enabled channels
    always_ff @(posedge sys_clk) begin
        if (!rst_n || tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end
    assign tick = (tick_cnt == 32'(REFRESH_CYCLES - 1));

    // alternate channels, skip a disabled one
    assign next_chan = cfg.out_en[!cur_chan] ? !cur_chan : cur_chan;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cur_chan <= 1'b0;
            dac_load <= 1'b0;
            dac_word <= '0;
        end else if (tick && |cfg.out_en) begin
            cur_chan <= next_chan;
            dac_load <= 1'b1;
            dac_word.chan <= next_chan;
            dac_word.code <= out_code(out_count[next_chan],
                cfg.out_4_20[next_chan], cfg.mode16, fault_active);
        end else begin
            dac_load <= 1'b0;
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // cycles since the last load while any output is enabled
    always_ff @(posedge sys_clk) begin
        if (!rst_n || dac_load || !(|cfg.out_en)) begin
            gap_cnt <= '0;
        end else begin
            gap_cnt <= gap_cnt + 1'b1;
        end
    end

    sequence s_read(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    sequence s_refresh_due;
        tick && |cfg.out_en && !$past(reg_wr);
    endsequence

    property p_mod_stat;
        s_read(`ADDR_MOD_STAT) |=> reg_rdata[15:4] == '0
            && reg_rdata[1] == !$past(supply_sync) && reg_rdata[0] == $past(fail_sync);
    endproperty
    a_mod_stat: assert property (p_mod_stat) else $error("module status byte wrong");

    property p_open_stat;
        s_read(`ADDR_OPEN_STAT) |=> reg_rdata == {12'h000, $past(open_loop)};
    endproperty
    a_open_stat: assert property (p_open_stat) else $error("open loop byte wrong");

    property p_spare;
        s_read(`ADDR_SPARE_STAT) |=> reg_rdata == '0;
    endproperty
    a_spare: assert property (p_spare) else $error("spare status not zero");

    property p_open_range;
        s_read(`ADDR_OPEN_STAT) |=> (reg_rdata[3:0] & ~$past(cfg.in_4_20)) == 4'h0;
    endproperty
    a_open_range: assert property (p_open_range) else $error("open loop outside 4-20");

    property p_open_set;
        pop && cfg.in_4_20[fifo_out.chan] && fifo_out.raw < `CODE_OPEN
            && !(reg_wr && reg_addr == `ADDR_CFG)
            ##1 !(reg_wr && reg_addr == `ADDR_CFG) |-> open_loop[$past(fifo_out.chan)];
    endproperty
    a_open_set: assert property (p_open_set) else $error("open loop not set");

    property p_mode15;
        pop && !cfg.mode16 |=> in_count[$past(fifo_out.chan)][15] == 1'b0;
    endproperty
    a_mode15: assert property (p_mode15) else $error("15-bit count overflow");

    property p_mode16_pass;
        pop && cfg.mode16 && !cfg.in_4_20[fifo_out.chan]
            |=> in_count[$past(fifo_out.chan)] == $past(fifo_out.raw);
    endproperty
    a_mode16_pass: assert property (p_mode16_pass) else $error("16-bit count wrong");

    property p_fault_level;
        tick && |cfg.out_en && fault_active ##1 $stable(cfg) |-> dac_load
            && dac_word.code == (cfg.out_4_20[dac_word.chan] ? `CODE_4MA : `CODE_ZERO);
    endproperty
    a_fault_level: assert property (p_fault_level) else $error("fault level wrong");

    property p_refresh;
        s_refresh_due |=> dac_load;
    endproperty
    a_refresh: assert property (p_refresh) else $error("refresh missed");

    property p_refresh_gap;
        gap_cnt <= 32'(REFRESH_CYCLES);
    endproperty
    a_refresh_gap: assert property (p_refresh_gap) else $error("refresh gap too long");

    property p_supply;
        $past(supply_ok_pin, 2) == 1'b0 && $past(rst_n, 2) |-> reg_rd ##1 reg_rdata[1]
            or !reg_rd;
    endproperty
    a_supply: assert property (p_supply) else $error("supply flag not set");
endmodule // analog_current_io_status_logic

// ---- rtl/in_scale.sv ----
// scales a hardware sample into the software count
`timescale 1ns/100ps
`include "aio_params.svh"
module in_scale (
    // sample and mode
    input wire logic [15:0] raw,
    input wire logic range_4_20,
    input wire logic mode16,
    // formatted count
    output logic [15:0] count
);
    logic [15:0] diff;
    logic [16:0] sum;
    logic [15:0] full;

    // 4-20 range: drop the live zero, stretch by 5/4 to full scale
    always_comb begin
        diff = raw - `CODE_4MA;
        sum = {1'b0, diff} + {3'b000, diff[15:2]};
        if (!range_4_20) begin
            full = raw;
        end else if (raw < `CODE_4MA) begin
            full = `CODE_ZERO;
        end else if (sum[16]) begin
            full = `CODE_MAX;
        end else begin
            full = sum[15:0];
        end
        // 15-bit mode halves, so the top bit is always clear
        count = mode16 ? full : {1'b0, full[15:1]};
    end
endmodule // in_scale

// ---- rtl/sample_fifo.sv ----
// small synchronous fifo for converter samples
`timescale 1ns/100ps
module sample_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] fill;
    logic push;
    logic pop;

    // honest full and empty from the fill count
    assign in_ready = (fill != (PW+1)'(DEPTH));
    assign out_valid = (fill != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // storage, no reset needed on the data
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers wrap, depth is a power of two
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
            if (push && !pop) fill <= fill + 1'b1;
            else if (pop && !push) fill <= fill - 1'b1;
        end
    end
endmodule // sample_fifo

// ---- verif/analog_current_io_status_logic_bench.sv ----
// self-checking bench for the analog current i/o status logic
`timescale 1ns/100ps
`include "aio_params.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fails++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module analog_current_io_status_logic_bench;
    import aio_pkg::*;
    // short refresh interval keeps the converter scans quick
    localparam int RC = 50;
    // cfg, channel, raw sample, expected count, expected open flags
    localparam logic [15:0] CASES [8][5] = '{
        '{16'h03FC, 16'h0000, 16'h2000, 16'h0000, 16'h0001},
        '{16'h03FC, 16'h0002, 16'hFFFF, 16'h7FFF, 16'h0000},
        '{16'h03FC, 16'h0003, 16'h3000, 16'h0000, 16'h0000},
        '{16'h03FC, 16'h0001, 16'h2FFF, 16'h0000, 16'h0002},
        '{16'h03FE, 16'h0001, 16'hFFFF, 16'hFFFF, 16'h0000},
        '{16'h003E, 16'h0000, 16'h2000, 16'h2000, 16'h0000},
        '{16'h003C, 16'h0000, 16'hFFFF, 16'h7FFF, 16'h0000},
        '{16'h003C, 16'h0003, 16'h0001, 16'h0000, 16'h0000}};
    logic sys_clk, rst_n, adc_valid, adc_ready, dac_load;
    logic supply_ok_pin, selftest_fail_pin, reg_wr, reg_rd;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    sample_t adc_sample;
    dac_word_t dac_word;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;

    // ==========================================================
    // clock, design and host model
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    analog_current_io_status_logic #(.REFRESH_CYCLES(RC)) dut_u (.sys_clk(sys_clk),
        .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_valid(adc_valid),
        .adc_ready(adc_ready), .adc_sample(adc_sample), .dac_load(dac_load),
        .dac_word(dac_word), .supply_ok_pin(supply_ok_pin),
        .selftest_fail_pin(selftest_fail_pin));
    host_bus_model host_u (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    // ==========================================================
    // verdict and hang guard
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ceiling is several times the expected run
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end

    // ==========================================================
    // offer one sample and hold it until taken; valid stays up afterwards
    task automatic push(input logic [1:0] ch, input logic [15:0] raw);
        int n;
        n = 0;
        adc_sample <= '{chan: ch, raw: raw};
        adc_valid <= 1'b1;
        @(negedge sys_clk);
        while (adc_ready !== 1'b1 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        `CHK(adc_ready, 1'b1)
        @(posedge sys_clk);
    endtask

    // status bytes at reset, unmapped read, supply loss and self test
    task automatic status_checks();
        // first read lands while the supply is still crossing the synchroniser
        host_u.rd(`ADDR_MOD_STAT, d);
        `CHK(d, 16'h000E)
        host_u.rd(`ADDR_SPARE_STAT, d);
        `CHK(d, 16'h0000)
        host_u.rd(8'hFF, d);
        `CHK(d, 16'h0000)
        host_u.rd(`ADDR_MOD_STAT, d);
        `CHK(d, 16'h0004)
        host_u.rd(`ADDR_OPEN_STAT, d);
        `CHK(d, 16'h0000)
        supply_ok_pin <= 1'b0;
        repeat (4) @(posedge sys_clk);
        host_u.rd(`ADDR_MOD_STAT, d);
        `CHK(d, 16'h000E)
        supply_ok_pin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        host_u.rd(`ADDR_MOD_STAT, d);
        `CHK(d, 16'h0004)
        selftest_fail_pin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        host_u.rd(`ADDR_MOD_STAT, d);
        `CHK(d, 16'h000D)
    endtask

    // formatting and open loop across ranges and resolutions
    task automatic conv_cases();
        for (int i = 0; i < 8; i++) begin
            host_u.wr(`ADDR_CFG, CASES[i][0]);
            push(CASES[i][1][1:0], CASES[i][2]);
            adc_valid <= 1'b0;
            repeat (3) @(posedge sys_clk);
            host_u.rd(`ADDR_IN0 + CASES[i][1][7:0], d);
            `CHK(d, CASES[i][3])
            host_u.rd(`ADDR_OPEN_STAT, d);
            `CHK(d, CASES[i][4])
        end
    endtask

    // fill the buffer while reads stall it, then drain and read all counts
    task automatic fill_drain();
        host_u.wr(`ADDR_CFG, 16'h03FC);
        fork
            host_u.rd_burst(12);
            begin
                for (int i = 0; i < 4; i++) begin
                    push(i[1:0], 16'hFFFF);
                end
                adc_valid <= 1'b0;
                @(negedge sys_clk);
                `CHK(adc_ready, 1'b0)
            end
        join
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(adc_ready, 1'b1)
        @(posedge sys_clk);
        for (int i = 0; i < 4; i++) begin
            host_u.rd_count(`ADDR_IN0 + i[7:0], d);
            `CHK(d, 16'h7FFF)
        end
        host_u.rd(`ADDR_MOD_STAT, d);
        `CHK(d, 16'h0000)
    endtask

    // watch six loads; the first two may still carry the old setting
    task automatic dac_scan(input logic [15:0] cfg, input logic [15:0] e0, e1);
        int gap [2];
        int loads;
        int n;
        int c;
        gap = '{0, 0};
        loads = 0;
        n = 0;
        host_u.wr(`ADDR_CFG, cfg);
        while (loads < 6 && n < 1000) begin
            @(negedge sys_clk);
            n++;
            gap[0]++;
            gap[1]++;
            if (dac_load === 1'b1) begin
                c = (dac_word.chan === 1'b1) ? 1 : 0;
                loads++;
                if (loads > 2) begin
                    `CHK(dac_word.code, c ? e1 : e0)
                    `CHK(gap[c] <= 2 * RC + 4, 1'b1)
                end
                gap[c] = 0;
            end
        end
        `CHK(loads, 6)
        @(posedge sys_clk);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        adc_valid = 1'b0;
        adc_sample = '0;
        supply_ok_pin = 1'b1;
        selftest_fail_pin = 1'b0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        status_checks();
        dac_scan(16'h03FC, 16'h3333, 16'h3333);
        selftest_fail_pin <= 1'b0;
        repeat (4) @(posedge sys_clk);
        conv_cases();
        fill_drain();
        dac_scan(16'h03FD, 16'h3333, 16'h3333);
        dac_scan(16'h03CD, 16'h0000, 16'h0000);
        host_u.wr(`ADDR_OUT0, 16'h1234);
        host_u.wr(`ADDR_OUT1, 16'hABCD);
        host_u.rd(`ADDR_OUT0, d);
        `CHK(d, 16'h1234)
        host_u.rd(`ADDR_OUT1, d);
        `CHK(d, 16'hABCD)
        dac_scan(16'h03CE, 16'h1234, 16'hABCD);
        host_u.rd(`ADDR_CFG, d);
        `CHK(d, 16'h03CE)
        // 4-20 outputs: live zero plus four fifths of the count
        dac_scan(16'h03FE, 16'h41C2, 16'hBCA3);
        conclude();
    end
endmodule // analog_current_io_status_logic_bench

// ---- verif/host_bus_model.sv ----
// host side master model for the register port of the status logic
`timescale 1ns/100ps
module host_bus_model (
    // clock
    input wire logic sys_clk,
    // register port
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata
);
    // ==========================================================
    // bus idle from time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // ==========================================================
    // one write; the extra edge stops a strobe being set twice in a step
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask

    // one read, data taken mid-cycle while it stands
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        v = reg_rdata;
        @(posedge sys_clk);
    endtask

    // back-to-back reads of the spare byte, which stall the sample drain
    task automatic rd_burst(input int n);
        reg_addr <= 8'h02;
        reg_rd <= 1'b1;
        repeat (n) @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
    endtask

    // counts are read once the input invalid flag is seen clear, or after 20 status reads
    task automatic rd_count(input logic [7:0] a, output logic [15:0] v);
        int n;
        n = 0;
        v = 16'hFFFF;
        while (v[2] !== 1'b0 && n < 20) begin
            rd(8'h00, v);
            n++;
        end
        rd(a, v);
    endtask
endmodule // host_bus_model
